/* verilog/chopt_ctrl.sv */
// option high byte register, low power gating, watchdog and auto-off
// assumes host writes/reads arrive as one-cycle strobes on clk_in
`timescale 1ns/1ps
module chopt_ctrl #(
    parameter int SEC_CYCLES = chopt_pkg::SECOND_CYCLES
)
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    input wire logic charge_current_wr_in,
    input wire logic charge_voltage_wr_in,
    input wire logic adapter_present_in,
    input wire logic lowpower_throttle_enable_in,
    input wire logic battery_present_cell_pin_in,
    input wire logic reverse_mode_in,
    input wire logic source_good_in,
    output chopt_pkg::chopt_lp_ctrl_t lp_ctrl_out,
    output logic charge_current_force_min_out,
    output logic input_limit_loop_clear_out,
    output logic source_good_output_out,
    output chopt_pkg::chopt_conv_cfg_t conv_cfg_out
);
    // the prescaler compares against SEC_CYCLES - 1; a single-cycle second would tick every cycle, but this check requires at least 2
    if (SEC_CYCLES < 2)
    begin : g_sec_check
        $error("SEC_CYCLES must be at least 2");
    end

    logic [7:0] opt_r;
    logic [7:0] rdata_r;
    logic [31:0] prescale_r;
    logic [7:0] sec_cnt_r;
    logic expired_r;
    logic [1:0] bat_sync_r;
    logic bat_prev_r;
    logic clear_r;

    wire own_sel = (reg_addr_in == chopt_pkg::CHOPT_ADDR);
    wire own_wr = reg_wr_in & own_sel;
    wire own_rd = reg_rd_in & own_sel;
    wire [7:0] rdata_nxt = own_rd ? opt_r : (reg_rd_in ? 8'h00 : rdata_r);

    wire low_power = opt_r[chopt_pkg::BIT_LOW_POWER];
    wire [1:0] wdt_sel = opt_r[chopt_pkg::BIT_WDT_HI:chopt_pkg::BIT_WDT_LO];
    wire auto_off = opt_r[chopt_pkg::BIT_AUTO_OFF];
    wire rev_good = opt_r[chopt_pkg::BIT_REV_SRC_GOOD];

    // battery-only low power; adapter presence overrides, the host should avoid it anyway
    wire lp_active = low_power & ~adapter_present_in; // [R1] [R4]
    wire lp_cmp_off = lp_active & ~lowpower_throttle_enable_in; // [R2]

    wire [7:0] wdt_period = (wdt_sel == chopt_pkg::WDT_SHORT) ? chopt_pkg::WDT_SHORT_S :
                            (wdt_sel == chopt_pkg::WDT_MID) ? chopt_pkg::WDT_MID_S :
                            chopt_pkg::WDT_LONG_S; // [R5]
    wire wdt_on = (wdt_sel != chopt_pkg::WDT_OFF);
    wire wdt_restart = charge_current_wr_in | charge_voltage_wr_in | own_wr; // [R7]
    wire sec_tick = (prescale_r == 32'(SEC_CYCLES - 1));
    wire wdt_expire = wdt_on & ~expired_r & sec_tick & (sec_cnt_r == wdt_period - 8'h01); // [R6]
    // expiry beats a same-cycle restart so the suspend event is never lost
    wire expired_nxt = wdt_expire ? 1'b1 : ((wdt_restart | ~wdt_on) ? 1'b0 : expired_r);
    wire count_hold = wdt_restart | ~wdt_on | expired_r | wdt_expire;
    wire [31:0] prescale_nxt = (count_hold | sec_tick) ? 32'h0 : prescale_r + 32'h1;
    wire [7:0] sec_cnt_nxt = count_hold ? 8'h00 : (sec_tick ? sec_cnt_r + 8'h01 : sec_cnt_r);

    wire bat_level = bat_sync_r[1];
    wire bat_fall = bat_prev_r & ~bat_level;

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            opt_r <= chopt_pkg::CHOPT_RESET; // [R14] [R4]
        else if (own_wr)
            opt_r <= reg_wdata_in; // [R14]
    end

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            rdata_r <= 8'h00;
        else
            rdata_r <= rdata_nxt;
    end

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            prescale_r <= 32'h0;
            sec_cnt_r <= 8'h00;
            expired_r <= 1'b0;
        end
        else
        begin
            prescale_r <= prescale_nxt;
            sec_cnt_r <= sec_cnt_nxt;
            expired_r <= expired_nxt; // [R6] [R7]
        end
    end

    // the pin is asynchronous: two stages before the edge detector looks at it
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            bat_sync_r <= 2'b00;
            bat_prev_r <= 1'b0;
            clear_r <= 1'b0;
        end
        else
        begin
            bat_sync_r <= {bat_sync_r[0], battery_present_cell_pin_in};
            bat_prev_r <= bat_level;
            clear_r <= bat_fall & auto_off; // [R8]
        end
    end

    // the loop enable bit lives in the low byte; only a clear pulse is sent,
    // so a later host write of one re-enables it there
    assign input_limit_loop_clear_out = clear_r; // [R8] [R9]
    assign reg_rdata_out = rdata_r;
    assign charge_current_force_min_out = expired_r; // [R6]
    assign lp_ctrl_out.regulator_off = lp_active; // [R1] [R3]
    assign lp_ctrl_out.throttle_alert_off = lp_cmp_off; // [R2]
    assign lp_ctrl_out.discharge_buf_off = lp_active; // [R1]
    assign lp_ctrl_out.power_buf_off = lp_active; // [R1]
    assign lp_ctrl_out.comparator_off = lp_cmp_off; // [R2]
    assign lp_ctrl_out.adc_off = lp_active; // [R1]
    assign source_good_output_out = source_good_in | (rev_good & reverse_mode_in); // [R10]
    assign conv_cfg_out.audible_floor_enable = opt_r[chopt_pkg::BIT_AUDIBLE]; // [R11]
    assign conv_cfg_out.switching_rate_select = opt_r[chopt_pkg::BIT_RATE]; // [R12]
    assign conv_cfg_out.passthrough_ripple_reduce = opt_r[chopt_pkg::BIT_RIPPLE]; // [R13]

    sequence s_pin_high;
        bat_level;
    endsequence

    sequence s_pin_low;
        !bat_level;
    endsequence

    sequence s_own_write;
        own_wr;
    endsequence

    sequence s_own_read;
        reg_rd_in && own_sel;
    endsequence

    a_write_readback: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R14]
        own_wr ##1 (reg_rd_in && own_sel) |=> (reg_rdata_out == $past(reg_wdata_in, 2)))
        else $error("register does not read back last write");

    a_unmapped_zero: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R14]
        (reg_rd_in && !own_sel) |=> (reg_rdata_out == 8'h00))
        else $error("unmapped read not zero");

    a_lowpower_gating: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R1]
        (low_power && !adapter_present_in) |-> (lp_ctrl_out.regulator_off &&
        lp_ctrl_out.adc_off && lp_ctrl_out.discharge_buf_off && lp_ctrl_out.power_buf_off))
        else $error("low power did not gate functions");

    a_lowpower_throttle: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R2]
        lp_ctrl_out.comparator_off == (lp_active && !lowpower_throttle_enable_in))
        else $error("comparator gating wrong");

    a_perf_mode_free: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R3]
        !low_power |-> (lp_ctrl_out == '0))
        else $error("performance mode gated a function");

    a_wdt_disabled: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R5]
        (wdt_sel == chopt_pkg::WDT_OFF) |=> !charge_current_force_min_out)
        else $error("disabled watchdog forced minimum");

    a_wdt_expire: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R6]
        (sec_tick && wdt_on && !expired_r && sec_cnt_r == wdt_period - 8'h01)
        |=> charge_current_force_min_out)
        else $error("watchdog expiry did not force minimum");

    a_wdt_restart: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R7]
        (wdt_restart && !wdt_expire) |=> (!charge_current_force_min_out && sec_cnt_r == 8'h00
        && prescale_r == 32'h0))
        else $error("watchdog did not restart");

    a_auto_off_clear: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R8]
        (s_pin_high ##1 (s_pin_low and auto_off)) |=> input_limit_loop_clear_out)
        else $error("auto-off did not clear loop enable");

    a_auto_off_idle: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R8]
        !$past(auto_off) |-> !input_limit_loop_clear_out)
        else $error("loop enable cleared without auto-off");

    a_source_good: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R10]
        (rev_good && reverse_mode_in) |-> source_good_output_out)
        else $error("source good not driven in reverse mode");

    a_conv_fields: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R12]
        own_wr |=> (conv_cfg_out.switching_rate_select == $past(reg_wdata_in[1])
        && conv_cfg_out.audible_floor_enable == $past(reg_wdata_in[2])))
        else $error("converter fields not updated by write");

    // register port: storage, read path and idle behaviour
    a_field_store: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R14]
        s_own_write |=> (opt_r == $past(reg_wdata_in)))
        else $error("write did not land in the register");

    a_hold_unwritten: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R14]
        !own_wr |=> $stable(opt_r))
        else $error("register changed without a write");

    a_read_value: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R14]
        s_own_read |=> (reg_rdata_out == $past(opt_r)))
        else $error("read returned wrong register value");

    a_rdata_stands: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R14]
        !reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data changed without a read");

    // converter configuration fields
    a_ripple_field: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R13]
        own_wr |=> (conv_cfg_out.passthrough_ripple_reduce ==
        $past(reg_wdata_in[chopt_pkg::BIT_RIPPLE])))
        else $error("ripple field not updated by write");

    a_audible_field: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R11]
        own_wr |=> (conv_cfg_out.audible_floor_enable ==
        $past(reg_wdata_in[chopt_pkg::BIT_AUDIBLE])))
        else $error("audible floor field not updated by write");

    a_rate_field: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R12]
        own_wr |=> (conv_cfg_out.switching_rate_select ==
        $past(reg_wdata_in[chopt_pkg::BIT_RATE])))
        else $error("switching rate field not updated by write");

    a_conv_steady: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R11]
        !own_wr |=> $stable(conv_cfg_out))
        else $error("converter fields changed without a write");

    // low power gating
    a_lowpower_field: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R1]
        own_wr |=> (low_power == $past(reg_wdata_in[chopt_pkg::BIT_LOW_POWER])))
        else $error("low power field not updated by write");

    a_adapter_override: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R1]
        adapter_present_in |-> (lp_ctrl_out == '0))
        else $error("gating active with adapter present");

    a_throttle_free: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R2]
        (lp_active && lowpower_throttle_enable_in) |->
        (!lp_ctrl_out.throttle_alert_off && !lp_ctrl_out.comparator_off))
        else $error("throttle profile blocked in low power");

    a_throttle_gated: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R1]
        (lp_active && !lowpower_throttle_enable_in) |->
        (lp_ctrl_out.throttle_alert_off && lp_ctrl_out.comparator_off))
        else $error("throttle alert not gated in low power");

    // source good in reverse mode
    a_source_good_pass: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R10]
        (!reverse_mode_in || !rev_good) |-> (source_good_output_out == source_good_in))
        else $error("source good altered outside reverse mode");

    a_rev_field: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R10]
        own_wr |=> (rev_good == $past(reg_wdata_in[chopt_pkg::BIT_REV_SRC_GOOD])))
        else $error("reverse source good field not updated");

    // watchdog counting and suspend
    a_wdt_field: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R5]
        own_wr |=> (wdt_sel == $past(reg_wdata_in[chopt_pkg::BIT_WDT_HI:chopt_pkg::BIT_WDT_LO])))
        else $error("watchdog field not updated by write");

    a_sec_range: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R5]
        wdt_on |-> (sec_cnt_r < wdt_period))
        else $error("second count beyond the period");

    a_prescale_range: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R5]
        prescale_r < 32'(SEC_CYCLES))
        else $error("prescaler beyond one second");

    a_wdt_idle_count: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R5]
        !wdt_on |=> (sec_cnt_r == 8'h00 && prescale_r == 32'h0))
        else $error("disabled watchdog kept counting");

    a_force_min_hold: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R6]
        (charge_current_force_min_out && !wdt_restart && wdt_on) |=>
        charge_current_force_min_out)
        else $error("suspend dropped without a restart");

    a_force_min_rise: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R6]
        $rose(charge_current_force_min_out) |-> $past(wdt_expire))
        else $error("suspend raised without expiry");

    a_force_min_drop: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R7]
        $fell(charge_current_force_min_out) |-> $past(wdt_restart || !wdt_on))
        else $error("suspend dropped without restart");

    // auto-off clear pulse
    a_auto_field: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R8]
        own_wr |=> (auto_off == $past(reg_wdata_in[chopt_pkg::BIT_AUTO_OFF])))
        else $error("auto-off field not updated by write");

    a_clear_single: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R8]
        input_limit_loop_clear_out |=> !input_limit_loop_clear_out)
        else $error("clear pulse longer than one cycle");

    a_clear_needs_fall: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R8]
        input_limit_loop_clear_out |-> $past(bat_fall && auto_off))
        else $error("clear pulse without a pin fall");
endmodule

/* pkg/chopt_pkg.sv */
// constants, field layout and carriers for the option high byte block
// assumes a byte-wide register port fed by the device's serial host front end
// Contract
// [R1] With low power set and only the battery present, the regulator is off and throttle alert, discharge and power monitor buffers, comparator and ADC are disabled.
// [R2] In low power mode the comparator and its throttle profile still run when the low power throttle enable is one.
// [R3] With low power clear, the battery-only device runs in performance mode and those functions follow their own settings.
// [R4] The host should not set low power while an adapter is present, and the bit resets to one.
// [R5] The watchdog field selects disabled, 5 s, 88 s or 175 s, and resets to 175 s.
// [R6] When an enabled watchdog period passes with no charge voltage or current write, charging is suspended by forcing charge current to minimum.
// [R7] After expiry the timer restarts on a write of charge current, charge voltage or the watchdog field.
// [R8] With auto-off set, a falling battery present pin clears the input current loop enable; with it clear nothing changes.
// [R9] After an automatic turn-off the host may set the input current loop enable again.
// [R10] With the reverse source good bit set, source good is driven high in reverse mode; the bit resets to zero.
// [R11] With the audible floor bit set (its reset value) light-load bursts stay above 25 kHz, otherwise unlimited.
// [R12] The switching rate bit selects 800 kHz at zero and 400 kHz at one, resetting to one.
// [R13] The pass-through ripple bit enables ripple reduction at one and resets to one.
// [R14] Every field is read/write, reads back the last write and loads its default at reset.
package chopt_pkg;
    localparam logic [7:0] CHOPT_ADDR = 8'h01;
    localparam logic [7:0] CHOPT_RESET = 8'hE7;
    localparam int BIT_LOW_POWER = 7;
    localparam int BIT_WDT_HI = 6;
    localparam int BIT_WDT_LO = 5;
    localparam int BIT_AUTO_OFF = 4;
    localparam int BIT_REV_SRC_GOOD = 3;
    localparam int BIT_AUDIBLE = 2;
    localparam int BIT_RATE = 1;
    localparam int BIT_RIPPLE = 0;
    localparam logic [1:0] WDT_OFF = 2'h0;
    localparam logic [1:0] WDT_SHORT = 2'h1;
    localparam logic [1:0] WDT_MID = 2'h2;
    localparam logic [1:0] WDT_LONG = 2'h3;
    localparam logic [7:0] WDT_SHORT_S = 8'h05;
    localparam logic [7:0] WDT_MID_S = 8'h58;
    localparam logic [7:0] WDT_LONG_S = 8'hAF;
    localparam int CLK_HZ = 25000000;
    localparam int SECOND_S = 1;
    localparam int SECOND_CYCLES = CLK_HZ * SECOND_S;

    typedef struct packed {
        logic regulator_off;
        logic throttle_alert_off;
        logic discharge_buf_off;
        logic power_buf_off;
        logic comparator_off;
        logic adc_off;
    } chopt_lp_ctrl_t;

    typedef struct packed {
        logic audible_floor_enable;
        logic switching_rate_select;
        logic passthrough_ripple_reduce;
    } chopt_conv_cfg_t;
endpackage

/* tb/chopt_host_model.sv */
// host model of the option byte port: one-cycle strobes, driven just after rising edges
// assumes the device clock and a registered read answer
`timescale 1ns/1ps
module chopt_host_model
(
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    output logic [7:0] addr_out,
    output logic wr_out,
    output logic rd_out,
    output logic [7:0] wdata_out
);
    initial
    begin
        addr_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in) #1;
        addr_out = a;
        wdata_out = d;
        wr_out = 1'b1;
        @(posedge clk_in) #1;
        wr_out = 1'b0;
        // idle data shows the inverse so a stale byte is never mistaken for fresh
        wdata_out = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in) #1;
        addr_out = a;
        rd_out = 1'b1;
        @(posedge clk_in) #1;
        rd_out = 1'b0;
        d = rdata_in;
    endtask
endmodule

/* tb/charger_option_high_byte_ctrl_tb.sv */
// self-checking bench for the option high byte block, short watchdog second
// assumes the host model file is compiled first
`timescale 1ns/1ps
module charger_option_high_byte_ctrl_tb;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [7:0] addr, wdata, rdata, d, q;
    logic wr, rd, ccw = 0, cvw = 0, adp = 0, lpt = 0, bat = 0, rev = 0, sg = 0, fmin, clr, sgo;
    chopt_pkg::chopt_lp_ctrl_t lp;
    chopt_pkg::chopt_conv_cfg_t cfg;
    int n_errors = 0;
    int cmp_count = 0;
    int k, n;
    always #20 clk_in = ~clk_in;
    chopt_host_model host_i (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .wr_out(wr),
        .rd_out(rd), .wdata_out(wdata));
    chopt_ctrl #(.SEC_CYCLES(4)) chopt_ctrl_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .charge_current_wr_in(ccw), .charge_voltage_wr_in(cvw),
        .adapter_present_in(adp), .lowpower_throttle_enable_in(lpt),
        .battery_present_cell_pin_in(bat), .reverse_mode_in(rev), .source_good_in(sg),
        .lp_ctrl_out(lp), .charge_current_force_min_out(fmin),
        .input_limit_loop_clear_out(clr), .source_good_output_out(sgo), .conv_cfg_out(cfg));
    function automatic logic [7:0] lp_exp(input logic l, input logic a, input logic t);
        return (l && !a) ? (t ? 8'h2D : 8'h3F) : 8'h00;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_fmin();
        for (k = 0; k < 24 && fmin !== 1'b1; k++) @(posedge clk_in) #1;
    endtask
    task automatic pulses(input int cycles);
        for (n = 0, k = 0; k < cycles; k++) @(posedge clk_in) #1 n += (clr === 1'b1);
    endtask
    task report_and_stop;
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #50us;
        n_errors++;
        report_and_stop;
    end
    initial
    begin
        void'($urandom(32'hBDFC));
        repeat (10) @(posedge clk_in);
        #1 arst_n_in = 1'b1;
        host_i.rd(8'h01, d);
        chk(d, chopt_pkg::CHOPT_RESET);
        chk({5'h00, cfg}, 8'h07);
        chk({2'h0, lp}, lp_exp(1'b1, 1'b0, 1'b0));
        for (int i = 0; i < 10; i++)
        begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            // an adapter never stands with low power requested
            adp = 1'($urandom) & ~d[7];
            lpt = 1'($urandom);
            rev = 1'($urandom);
            sg = 1'($urandom);
            host_i.wr(8'h01, d);
            chk({5'h00, cfg}, {5'h00, d[2:0]});
            chk({2'h0, lp}, lp_exp(d[7], adp, lpt));
            chk({7'h00, sgo}, {7'h00, sg | (d[3] & rev)});
            host_i.rd(8'h01, q);
            chk(q, d);
        end
        host_i.wr(8'h02, 8'h5A);
        host_i.rd(8'h01, q);
        chk(q, d);
        host_i.rd(8'h02, q);
        chk(q, 8'h00);
        adp = 1'b0;
        host_i.wr(8'h01, 8'h20);
        chk({2'h0, lp}, 8'h00);
        repeat (15) @(posedge clk_in) #1;
        chk({7'h00, fmin}, 8'h00);
        wait_fmin();
        chk({7'h00, fmin}, 8'h01);
        ccw = 1'b1;
        @(posedge clk_in) #1 ccw = 1'b0;
        @(posedge clk_in) #1;
        chk({7'h00, fmin}, 8'h00);
        wait_fmin();
        chk({7'h00, fmin}, 8'h01);
        cvw = 1'b1;
        @(posedge clk_in) #1 cvw = 1'b0;
        @(posedge clk_in) #1;
        chk({7'h00, fmin}, 8'h00);
        host_i.wr(8'h01, 8'h00);
        repeat (30) @(posedge clk_in) #1;
        chk({7'h00, fmin}, 8'h00);
        for (int m = 1; m >= 0; m--)
        begin
            bat = 1'b1;
            host_i.wr(8'h01, m ? 8'h10 : 8'h00);
            repeat (4) @(posedge clk_in) #1;
            bat = 1'b0;
            pulses(8);
            chk(8'(n), 8'(m));
        end
        report_and_stop;
    end
endmodule
